// ==== include/wic_pkg.sv ====
// Constants, field layout and types for the wake and interrupt config block
package wic_pkg;

    // ==========================================================
    // Serial frame layout
    localparam int          FRAME_BITS   = 16;
    localparam logic [4:0]  FRAME_LEN    = 5'h10;
    localparam int          BIT_RW       = 15;
    localparam int          SEL_HI       = 14;
    localparam int          SEL_LO       = 9;
    localparam int          BIT_PARITY   = 8;
    localparam logic [4:0]  LOW_BYTE_AT  = 5'h08;
    localparam logic [5:0]  SEL_PIN_WAKE = 6'h05;
    localparam logic [5:0]  SEL_INT_CFG  = 6'h06;

    // ==========================================================
    // Pin wake configuration fields
    localparam int          PW_PIN3_LO   = 6;
    localparam int          PW_PIN4_LO   = 4;
    localparam int          PW_PIN5_LO   = 2;
    localparam int          PW_INH23     = 1;
    localparam int          PW_INH45     = 0;
    localparam logic [7:0]  PIN_WAKE_RST = 8'h00;

    // ==========================================================
    // Interrupt configuration fields
    localparam int          IC_DURATION  = 7;
    localparam int          IC_INH_LIN   = 6;
    localparam int          IC_INH_ALL   = 5;
    localparam int          IC_INH_VSNS  = 4;
    localparam int          IC_INH_VPRE  = 3;
    localparam int          IC_INH_VCORE = 2;
    localparam int          IC_INH_VOTH  = 1;
    localparam int          IC_INH_CAN   = 0;
    localparam logic [7:0]  INT_CFG_RST  = 8'h00;

    // ==========================================================
    // Status byte positions
    localparam int          ST_SPI       = 7;
    localparam int          ST_WAKE      = 6;
    localparam int          ST_CAN       = 5;
    localparam int          ST_LIN       = 4;
    localparam int          ST_IO        = 3;
    localparam int          ST_VPRE      = 2;
    localparam int          ST_VCORE     = 1;
    localparam int          ST_VOTH      = 0;

    // ==========================================================
    // Timing
    localparam longint      CLK_HZ       = 50_000_000;
    localparam longint      INT_LONG_NS  = 100_000;
    localparam longint      INT_SHORT_NS = 25_000;
    localparam int          INT_LONG_CYC =
        int'(INT_LONG_NS * CLK_HZ / 1_000_000_000);
    localparam int          INT_SHORT_CYC =
        int'(INT_SHORT_NS * CLK_HZ / 1_000_000_000);

    // ==========================================================
    // Types
    typedef enum logic [1:0]
    {
        WIC_EDGE_NONE = 2'b00,
        WIC_EDGE_RISE = 2'b01,
        WIC_EDGE_FALL = 2'b10,
        WIC_EDGE_ANY  = 2'b11
    } wic_edge_t;

    typedef enum logic [1:0]
    {
        WIC_FR_IDLE   = 2'b00,
        WIC_FR_ACTIVE = 2'b01
    } wic_frame_t;

endpackage

// ==== rtl/wic_config_regs.sv ====
// Serial-accessed wake and interrupt configuration registers
`timescale 1ns/1ps

module wic_config_regs
    import wic_pkg::*;
#(
    parameter int PULSE_W   = 13,
    parameter int LONG_CYC  = INT_LONG_CYC,
    parameter int SHORT_CYC = INT_SHORT_CYC
)
(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               other_rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               mosi,
    output logic                    miso,
    output logic                    miso_oe_n,
    input  wire logic               low_power,
    input  wire logic [2:0]         io_pin_345,
    input  wire logic [5:0]         io_status,
    input  wire logic [5:0]         io_event,
    input  wire logic               can_flag,
    input  wire logic               lin_flag,
    input  wire logic               vpre_flag,
    input  wire logic               vcore_flag,
    input  wire logic               vothers_flag,
    input  wire logic               can_event,
    input  wire logic               lin_event,
    input  wire logic               vsns_event,
    input  wire logic               vpre_event,
    input  wire logic               vcore_event,
    input  wire logic               vothers_event,
    output logic                    int_request,
    output logic [PULSE_W-1:0]      int_pulse_cycles,
    output logic                    wake_event,
    output logic [7:0]              pin_wake_cfg,
    output logic [7:0]              int_cfg
);

    // ==========================================================
    // Synchronised pins
    logic [2:0] link_lvl;
    logic [2:0] io_lvl;
    logic       sclk_s;
    logic       cs_n_s;
    logic       mosi_s;
    logic       sclk_q;
    logic       cs_n_q;
    logic [2:0] io_q;

    assign sclk_s = link_lvl[2];
    assign cs_n_s = link_lvl[1];
    assign mosi_s = link_lvl[0];

    wic_pin_sync #(.W(3), .RST_VAL(3'h2)) u_link_sync
    (
        .clock  (clock),
        .nrst   (nrst),
        .pin_in ({sclk, cs_n, mosi}),
        .level  (link_lvl)
    );

    wic_pin_sync #(.W(3), .RST_VAL(3'h0)) u_io_sync
    (
        .clock  (clock),
        .nrst   (nrst),
        .pin_in (io_pin_345),
        .level  (io_lvl)
    );

    wire sclk_rise = sclk_s & ~sclk_q;
    wire sclk_fall = ~sclk_s & sclk_q;
    wire cs_start  = ~cs_n_s & cs_n_q;
    wire cs_end    = cs_n_s & ~cs_n_q;

    // ==========================================================
    // Frame state
    wic_frame_t  state;
    wic_frame_t  next_state;
    logic [4:0]  bit_cnt;
    logic [15:0] rx_word;
    logic [15:0] tx_word;
    logic        spi_g;
    logic        wake_flag;
    logic        io_g;

    wire [7:0] status_byte;
    assign status_byte = {spi_g, wake_flag, can_flag, lin_flag,
                          io_g, vpre_flag, vcore_flag, vothers_flag};

    // Selector is complete after eight falling edges
    wire [5:0] early_sel = rx_word[6:1];
    wire [7:0] early_rd  =
        (early_sel == SEL_PIN_WAKE) ? pin_wake_cfg :
        (early_sel == SEL_INT_CFG)  ? int_cfg      : 8'h00;

    wire [3:0] tx_idx    = 4'(5'h0f - bit_cnt);
    wire       at_low    = (bit_cnt == LOW_BYTE_AT);
    wire       in_frame  = (bit_cnt < FRAME_LEN);
    wire       next_miso = at_low ? early_rd[7] : tx_word[tx_idx];

    // Frame decode at chip select release
    wire [5:0] fr_sel    = rx_word[SEL_HI:SEL_LO];
    wire       fr_write  = rx_word[BIT_RW];
    wire       fr_len_ok = (bit_cnt == FRAME_LEN);
    wire       fr_par_ok = ^rx_word;
    wire       sel_pw    = (fr_sel == SEL_PIN_WAKE);
    wire       sel_ic    = (fr_sel == SEL_INT_CFG);
    wire       sel_ok    = sel_pw | sel_ic;
    wire       rd_zero   = (rx_word[BIT_PARITY:0] == 9'h000);
    wire       fr_good   = fr_len_ok & sel_ok
                           & (fr_write ? fr_par_ok : rd_zero);
    wire       commit    = (state == WIC_FR_ACTIVE) & cs_end;
    wire       do_write  = commit & fr_good & fr_write;
    wire       wr_pw     = do_write & sel_pw;
    wire       wr_ic     = do_write & sel_ic;
    wire       rd_pw     = commit & fr_good & ~fr_write & sel_pw;

    always_comb
    begin
        next_state = state;
        case (state)
            WIC_FR_IDLE:
            begin
                if (cs_start)
                begin
                    next_state = WIC_FR_ACTIVE;
                end
            end
            WIC_FR_ACTIVE:
            begin
                if (cs_end)
                begin
                    next_state = WIC_FR_IDLE;
                end
            end
            default:
            begin
                next_state = WIC_FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst)
        begin
            state  <= WIC_FR_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            state  <= next_state;
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
        end
    end

    // Receive shift, MSB first, sampled on falling clock edges
    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst || cs_start)
        begin
            bit_cnt <= 5'h00;
            rx_word <= 16'h0000;
        end
        else if (state == WIC_FR_ACTIVE && sclk_fall && in_frame)
        begin
            bit_cnt <= bit_cnt + 5'h01;
            rx_word <= {rx_word[14:0], mosi_s};
        end
    end

    // Answer: status byte, then contents before this frame's write
    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst)
        begin
            tx_word   <= 16'h0000;
            miso      <= 1'b0;
            miso_oe_n <= 1'b1;
        end
        else if (cs_start)
        begin
            tx_word   <= {status_byte, 8'h00};
            miso      <= status_byte[7];
            miso_oe_n <= 1'b0;
        end
        else if (cs_end)
        begin
            miso      <= 1'b0;
            miso_oe_n <= 1'b1;
        end
        else if (state == WIC_FR_ACTIVE && sclk_rise && in_frame
                 && bit_cnt != 5'h00)
        begin
            if (at_low)
            begin
                tx_word[7:0] <= early_rd;
            end
            miso <= next_miso;
        end
    end

    // SPI error flag reflects the outcome of the last frame
    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst)
        begin
            spi_g <= 1'b0;
        end
        else if (commit)
        begin
            spi_g <= ~fr_good;
        end
    end

    // ==========================================================
    // Configuration registers, power-on reset only
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pin_wake_cfg <= PIN_WAKE_RST;
            int_cfg      <= INT_CFG_RST;
        end
        else
        begin
            if (wr_pw)
            begin
                pin_wake_cfg <= rx_word[7:0];
            end
            if (wr_ic)
            begin
                int_cfg <= rx_word[7:0];
            end
        end
    end

    // ==========================================================
    // Wake detection
    wic_edge_t sel3;
    wic_edge_t sel4;
    wic_edge_t sel5;
    assign sel3 = wic_edge_t'(pin_wake_cfg[PW_PIN3_LO +: 2]);
    assign sel4 = wic_edge_t'(pin_wake_cfg[PW_PIN4_LO +: 2]);
    assign sel5 = wic_edge_t'(pin_wake_cfg[PW_PIN5_LO +: 2]);

    wire [2:0] io_rise = io_lvl & ~io_q;
    wire [2:0] io_fall = ~io_lvl & io_q;
    wire [5:0] sel_all = {sel3, sel4, sel5};

    // Bit 0 of a code enables rising, bit 1 falling
    wire [2:0] match;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_match
            assign match[gi] = (io_rise[2-gi] & sel_all[4-2*gi])
                             | (io_fall[2-gi] & sel_all[5-2*gi]);
        end
    endgenerate

    wire wake_hit = low_power & (|match);

    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst)
        begin
            io_q       <= 3'h0;
            wake_flag  <= 1'b0;
            wake_event <= 1'b0;
        end
        else
        begin
            io_q       <= io_lvl;
            wake_event <= wake_hit;
            // Set wins over the clear by a read
            wake_flag  <= wake_hit | (wake_flag & ~rd_pw);
        end
    end

    // ==========================================================
    // Interrupt gating
    wire [5:0] io_keep = {{2{~pin_wake_cfg[PW_INH45]}},
                          {2{~pin_wake_cfg[PW_INH23]}},
                          2'b11};
    // Masking keeps safety-role pins quiet
    wire io_int  = |(io_event & io_keep);
    wire src_int = (can_event     & ~int_cfg[IC_INH_CAN])
                 | (lin_event     & ~int_cfg[IC_INH_LIN])
                 | (vsns_event    & ~int_cfg[IC_INH_VSNS])
                 | (vpre_event    & ~int_cfg[IC_INH_VPRE])
                 | (vcore_event   & ~int_cfg[IC_INH_VCORE])
                 | (vothers_event & ~int_cfg[IC_INH_VOTH]);
    wire next_int = ~int_cfg[IC_INH_ALL] & (io_int | src_int);

    wire [PULSE_W-1:0] long_len  = PULSE_W'(LONG_CYC);
    wire [PULSE_W-1:0] short_len = PULSE_W'(SHORT_CYC);
    wire [PULSE_W-1:0] next_len  =
        int_cfg[IC_DURATION] ? short_len : long_len;

    always_ff @(posedge clock)
    begin
        if (!nrst || other_rst)
        begin
            int_request      <= 1'b0;
            io_g             <= 1'b0;
        end
        else
        begin
            int_request      <= next_int;
            io_g             <= |(io_status & io_keep);
        end
    end

    // Config survives a soft reset, so the length must follow it
    always_ff @(posedge clock)
    begin
        int_pulse_cycles <= nrst ? next_len : long_len;
    end

endmodule

// ==== rtl/wic_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module wic_pin_sync
    import wic_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_level;

    // Bit updates only when the two settled stages agree
    assign next_level = (stage2 & stage3) | (level & (stage2 ^ stage3));

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            level  <= RST_VAL;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the wake and interrupt config block
`timescale 1ns/1ps
module tb_top
    import wic_pkg::*;
;
    // ==========
    // Signals and model state
    localparam int INH [6] = '{IC_INH_CAN, IC_INH_LIN, IC_INH_VSNS,
                               IC_INH_VPRE, IC_INH_VCORE, IC_INH_VOTH};
    logic        clock, nrst, other_rst, low_power;
    logic        sclk, cs_n, mosi, miso, miso_oe_n;
    logic        int_request, wake_event, spi_g, wk;
    logic [2:0]  pins;
    logic [5:0]  ios;
    logic [4:0]  fl;
    logic [11:0] ev;
    logic [12:0] pulse;
    logic [7:0]  pw_q, ic_q, pw, ic;
    logic [31:0] rs;
    int          n_errors, checked, p;
    int          cyc = 0;

    wic_config_regs #(.LONG_CYC(50), .SHORT_CYC(12)) u_wic_config_regs (
        .clock(clock), .nrst(nrst), .other_rst(other_rst), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
        .low_power(low_power), .io_pin_345(pins), .io_status(ios),
        .io_event(ev[11:6]), .can_flag(fl[4]), .lin_flag(fl[3]),
        .vpre_flag(fl[2]), .vcore_flag(fl[1]), .vothers_flag(fl[0]),
        .can_event(ev[0]), .lin_event(ev[1]), .vsns_event(ev[2]),
        .vpre_event(ev[3]), .vcore_event(ev[4]), .vothers_event(ev[5]),
        .int_request(int_request), .int_pulse_cycles(pulse),
        .wake_event(wake_event), .pin_wake_cfg(pw_q), .int_cfg(ic_q));
    wic_spi_master u_wic_spi_master (.clock(clock), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    function automatic logic [15:0] wr(input logic [5:0] s, input logic [7:0] d);
        logic [15:0] f;
        f = {1'b1, s, 1'b0, d};
        f[8] = ~^f;
        return f;
    endfunction

    function automatic logic [15:0] rd(input logic [5:0] s);
        return {1'b0, s, 9'h000};
    endfunction

    function automatic logic [7:0] st();
        logic [5:0] m;
        m = {{2{~pw[PW_INH45]}}, {2{~pw[PW_INH23]}}, 2'b11};
        return {spi_g, wk, fl[4:3], |(ios & m), fl[2:0]};
    endfunction

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [15:0] f);
        logic [15:0] rx, ex;
        logic        ok, pwsel;
        pwsel = f[14:9] == SEL_PIN_WAKE;
        ok = (pwsel || f[14:9] == SEL_INT_CFG)
             && (f[15] ? ^f : f[8:0] == 9'h000);
        ex = {st(), pwsel ? pw : f[14:9] == SEL_INT_CFG ? ic : 8'h00};
        u_wic_spi_master.xfer(f, 4 + int'(rnd() % 3), rx);
        cmp(rx, ex);
        spi_g = !ok;
        if (ok && f[15] && pwsel)
            pw = f[7:0];
        if (ok && f[15] && !pwsel)
            ic = f[7:0];
        if (ok && !f[15] && pwsel)
            wk = 1'b0;
        cmp({pw_q, ic_q}, {pw, ic});
        cmp(16'(pulse), 16'(ic[IC_DURATION] ? 12 : 50));
    endtask

    task automatic fire(input int i);
        logic e;
        e = !ic[IC_INH_ALL] && (i < 6 ? !ic[INH[i]] : i < 8 ? 1'b1
            : i < 10 ? !pw[PW_INH23] : !pw[PW_INH45]);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
        @(negedge clock);
        cmp(16'(int_request), 16'(e));
        @(posedge clock);
    endtask

    task automatic wake(input int q, input logic v, input logic e);
        int n;
        n = 0;
        pins[2-q] <= v;
        repeat (20)
        begin
            @(posedge clock);
            #1;
            if (wake_event === 1'b1)
                n++;
        end
        if (e)
            wk = 1'b1;
        cmp(16'(n), 16'(e));
    endtask

    task automatic finish_test();
        $display("Errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end

    // ==========
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        other_rst = 1'b0;
        low_power = 1'b0;
        {pins, ios, fl, ev} = '0;
        {pw, ic, spi_g, wk} = '0;
        {n_errors, checked} = '0;
        rs = 32'h706d;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (6) @(posedge clock);
        frame(rd(SEL_PIN_WAKE));
        frame(rd(SEL_INT_CFG));
        for (int k = 0; k < 8; k++)
        begin
            fl <= 5'(rnd());
            ios <= 6'(rnd());
            @(posedge clock);
            frame(wr(SEL_PIN_WAKE, 8'(rnd())));
            frame(wr(SEL_INT_CFG, 8'(rnd())));
            frame(rd(SEL_PIN_WAKE));
            for (int i = 0; i < 12; i++)
                fire(i);
        end
        frame(wr(SEL_PIN_WAKE, 8'h03) ^ 16'h0100);
        frame(wr(6'h3f, 8'h55));
        frame(rd(SEL_INT_CFG) | 16'h0001);
        frame(wr(SEL_INT_CFG, 8'h80));
        frame(wr(SEL_PIN_WAKE, 8'hc3));
        wake(0, 1'b1, 1'b0);
        wake(0, 1'b0, 1'b0);
        for (int c = 0; c < 12; c++)
        begin
            p = c / 4;
            frame(wr(SEL_PIN_WAKE, 8'((c % 4) << (6 - 2 * p))));
            low_power <= 1'b1;
            wake(p, 1'b1, c[0]);
            wake(p, 1'b0, c[1]);
            low_power <= 1'b0;
            frame(rd(SEL_PIN_WAKE));
        end
        other_rst <= 1'b1;
        @(posedge clock);
        other_rst <= 1'b0;
        {spi_g, wk} = '0;
        repeat (4) @(posedge clock);
        frame(rd(SEL_PIN_WAKE));
        nrst <= 1'b0;
        @(posedge clock);
        nrst <= 1'b1;
        {pw, ic} = '0;
        repeat (6) @(posedge clock);
        frame(rd(SEL_INT_CFG));
        finish_test();
    end
endmodule

// ==== sim/wic_checker.sv ====
// Port-level assertions for the wake and interrupt config block
`timescale 1ns/1ps
module wic_checker
    import wic_pkg::*;
#(
    parameter int PULSE_W   = 13,
    parameter int LONG_CYC  = 5000,
    parameter int SHORT_CYC = 1250
)
(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               other_rst,
    input  wire logic               cs_n,
    input  wire logic               miso_oe_n,
    input  wire logic               low_power,
    input  wire logic               can_event,
    input  wire logic               int_request,
    input  wire logic [PULSE_W-1:0] int_pulse_cycles,
    input  wire logic               wake_event,
    input  wire logic [7:0]         pin_wake_cfg,
    input  wire logic [7:0]         int_cfg
);
    // ==========
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_reset_clear: assert property ($rose(nrst) |->
        pin_wake_cfg == PIN_WAKE_RST && int_cfg == INT_CFG_RST)
        else $error("config not cleared by power-on reset");
    a_soft_keep: assert property (other_rst |=>
        $stable(pin_wake_cfg) && $stable(int_cfg))
        else $error("config changed by other reset");
    a_idle_hold: assert property (cs_n [*8] |=>
        $stable(pin_wake_cfg) && $stable(int_cfg))
        else $error("config changed outside a frame");
    a_oe_idle: assert property (cs_n [*8] |-> miso_oe_n)
        else $error("data out driven while deselected");
    a_oe_drive: assert property (!cs_n [*8] |-> !miso_oe_n)
        else $error("data out not driven in a frame");
    a_pulse_len: assert property ($stable(int_cfg) |=>
        int_pulse_cycles == PULSE_W'($past(int_cfg[IC_DURATION]) ?
        SHORT_CYC : LONG_CYC))
        else $error("pulse length mismatch");
    a_inh_all: assert property ($past(int_cfg[IC_INH_ALL]) |->
        !int_request)
        else $error("interrupt while all inhibited");
    a_can_int: assert property (can_event && !other_rst &&
        !int_cfg[IC_INH_ALL] && !int_cfg[IC_INH_CAN] |=> int_request)
        else $error("missing interrupt for bus error");
    a_wake_gate: assert property (wake_event |-> $past(low_power))
        else $error("wake outside low power");
    a_wake_none: assert property ($past(pin_wake_cfg[7:2]) == 6'h00 |->
        !wake_event)
        else $error("wake with no edge selected");
    a_wake_pulse: assert property (wake_event |=> !wake_event)
        else $error("wake pulse too long");

    c_write: cover property (!$stable(pin_wake_cfg));
    c_int: cover property (int_request);
    c_wake: cover property (wake_event);
endmodule

bind wic_config_regs wic_checker #(.PULSE_W(PULSE_W),
    .LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_wic_checker (
    .clock(clock), .nrst(nrst), .other_rst(other_rst), .cs_n(cs_n),
    .miso_oe_n(miso_oe_n), .low_power(low_power), .can_event(can_event),
    .int_request(int_request), .int_pulse_cycles(int_pulse_cycles),
    .wake_event(wake_event), .pin_wake_cfg(pin_wake_cfg),
    .int_cfg(int_cfg));

// ==== sim/wic_spi_master.sv ====
// Serial bus master model that runs frames into the config block
`timescale 1ns/1ps
module wic_spi_master
(
    input  wire logic clock,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe_n
);
    // ==========
    // Frame transfer; serial clock stands low between frames
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    task automatic xfer(input logic [15:0] f, input int half,
                        output logic [15:0] rx);
        @(posedge clock);
        cs_n <= 1'b0;
        mosi <= f[15];
        repeat (2 * half) @(posedge clock);
        for (int i = 15; i >= 0; i--)
        begin
            sclk <= 1'b1;
            mosi <= f[i];
            repeat (half) @(posedge clock);
            sclk <= 1'b0;
            repeat (half) @(posedge clock);
            // Bit has settled long before the next rise replaces it
            // Undriven line never passes as a match
            rx[i] = miso_oe_n ? 1'bx : miso;
        end
        cs_n <= 1'b1;
        mosi <= ~f[0];
        repeat (12) @(posedge clock);
    endtask
endmodule
